// ### pftd_core.sv
// force override, event priority, conversion-start prescale and dead-band for one pwm pair
// assumes all event strobes come from time-base logic on ref_clk, one cycle wide
// Contract
// - software force beats every counter event
// - down-count order: force, zero, t1, t2, cb, ca, period
// - up-count order: force, period, t1, t2, cb, ca, zero
// - force code 01 low, 10 high, else none
// - force b at bits 3:2, a at 1:0
// - active force change reaches output two cycles later
// - force shadow reloads on zero, period or either
// - no immediate force load, only via reload
// - one 4-bit event counter per trigger channel
// - source select and compare pair pick increment event
// - pair select picks first or second period
// - pulse at period count, only when enabled
// - four-bit period field per channel per pair
// - event counter starts from init register value
// - event select bit layout as specified
// - delays count cycles, or half cycles
// - delay values shadowed, loaded per load mode
// - input mode, polarity and bypass per path
// - swap 00 pass, 01 a, 10 b, 11 cross
// - dual-edge puts both delays on b path
`include "pftd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pftd_core
  import pftd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`PFTD_AW-1:0] reg_addr,
  input wire logic [`PFTD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`PFTD_DW-1:0] reg_rdata,
  input wire logic [1:0] cnt_mode,
  input wire logic cnt_dir_up,
  input wire logic ctr_zero,
  input wire logic ctr_period,
  input wire logic t1_up,
  input wire logic t1_dn,
  input wire logic t2_up,
  input wire logic t2_dn,
  input wire logic [3:0] cmp_up,
  input wire logic [3:0] cmp_dn,
  input wire logic [2*`PFTD_NEV-1:0] act_a,
  input wire logic [2*`PFTD_NEV-1:0] act_b,
  output logic pwm_output_a,
  output logic pwm_output_b,
  output logic conversion_start_pulse_a,
  output logic conversion_start_pulse_b
);

  // register file
  logic [3:0] force_shadow_ff;
  logic [3:0] force_active_ff;
  logic [1:0] force_reload_select_ff;
  logic [15:0] event_select_register_ff;
  logic [15:0] event_prescale_register_ff;
  logic [15:0] second_prescale_register_ff;
  logic [7:0] counter_init_register_ff;
  logic [13:0] deadband_control_register_ff;
  logic [`PFTD_DLY_W-1:0] dly_shadow_ff [2];
  logic [`PFTD_DLY_W-1:0] dly_active_ff [2];
  logic [3:0] evt_cnt_ff [2];
  logic [`PFTD_DW-1:0] rdata_ff;

  wire wr_force = reg_wr && (reg_addr == `PFTD_ADDR_FORCE);
  wire wr_reload = reg_wr && (reg_addr == `PFTD_ADDR_FORCE_RELOAD);
  wire wr_sel = reg_wr && (reg_addr == `PFTD_ADDR_EVT_SEL);
  wire wr_ps = reg_wr && (reg_addr == `PFTD_ADDR_EVT_PRESCALE);
  wire wr_ps2 = reg_wr && (reg_addr == `PFTD_ADDR_SECOND_PRESCALE);
  wire wr_init = reg_wr && (reg_addr == `PFTD_ADDR_CNT_INIT);
  wire wr_db = reg_wr && (reg_addr == `PFTD_ADDR_DB_CTRL);
  wire wr_rise = reg_wr && (reg_addr == `PFTD_ADDR_RISE_DLY);
  wire wr_fall = reg_wr && (reg_addr == `PFTD_ADDR_FALL_DLY);

  // force shadow and its reload
  wire [1:0] rld_sel = force_reload_select_ff;
  wire force_reload = ((rld_sel == 2'h0) && ctr_zero) ||
                      ((rld_sel == 2'h1) && ctr_period) ||
                      ((rld_sel == 2'h2) && (ctr_zero || ctr_period));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      force_shadow_ff <= `PFTD_RST_4;
      force_active_ff <= `PFTD_RST_4;
      force_reload_select_ff <= `PFTD_RST_2;
    end else begin
      if (wr_force)
        force_shadow_ff <= reg_wdata[3:0];
      if (wr_reload)
        force_reload_select_ff <= reg_wdata[1:0];
      // active copy changes only on the reload event
      if (force_reload)
        force_active_ff <= force_shadow_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      event_select_register_ff <= `PFTD_RST_16;
      event_prescale_register_ff <= `PFTD_RST_16;
      second_prescale_register_ff <= `PFTD_RST_16;
      counter_init_register_ff <= 8'h00;
      deadband_control_register_ff <= `PFTD_DLY_W'(0);
    end else begin
      if (wr_sel)
        event_select_register_ff <= reg_wdata & 16'hff3f;
      if (wr_ps)
        event_prescale_register_ff <= reg_wdata & 16'h8f0f;
      if (wr_ps2)
        second_prescale_register_ff <= reg_wdata & 16'h0f0f;
      if (wr_init)
        counter_init_register_ff <= reg_wdata[7:0];
      if (wr_db)
        deadband_control_register_ff <= reg_wdata[13:0] & `PFTD_DB_USED;
    end
  end

  // action qualifier: priority resolution
  typedef logic [3:0] ev_order_t [`PFTD_NEV];
  localparam ev_order_t ORD_UP = '{`PFTD_EV_PRD, `PFTD_EV_T1U, `PFTD_EV_T2U, `PFTD_EV_CBU,
    `PFTD_EV_CAU, `PFTD_EV_ZRO, `PFTD_EV_T1D, `PFTD_EV_T2D, `PFTD_EV_CBD, `PFTD_EV_CAD};
  localparam ev_order_t ORD_DN = '{`PFTD_EV_ZRO, `PFTD_EV_T1D, `PFTD_EV_T2D, `PFTD_EV_CBD,
    `PFTD_EV_CAD, `PFTD_EV_PRD, `PFTD_EV_T1U, `PFTD_EV_T2U, `PFTD_EV_CBU, `PFTD_EV_CAU};
  localparam ev_order_t ORD_UDI = '{`PFTD_EV_T1U, `PFTD_EV_T2U, `PFTD_EV_CBU, `PFTD_EV_CAU,
    `PFTD_EV_ZRO, `PFTD_EV_T1D, `PFTD_EV_T2D, `PFTD_EV_CBD, `PFTD_EV_CAD, `PFTD_EV_PRD};
  localparam ev_order_t ORD_UDD = '{`PFTD_EV_T1D, `PFTD_EV_T2D, `PFTD_EV_CBD, `PFTD_EV_CAD,
    `PFTD_EV_PRD, `PFTD_EV_T1U, `PFTD_EV_T2U, `PFTD_EV_CBU, `PFTD_EV_CAU, `PFTD_EV_ZRO};

  wire [`PFTD_NEV-1:0] evt = {cmp_dn[0], cmp_up[0], cmp_dn[1], cmp_up[1],
                              t2_dn, t2_up, t1_dn, t1_up, ctr_period, ctr_zero};

  // highest-priority firing event with a real action wins
  function automatic logic [1:0] resolve(input ev_order_t ord,
                                         input logic [`PFTD_NEV-1:0] ev,
                                         input logic [2*`PFTD_NEV-1:0] act);
    logic [1:0] res;
    logic [1:0] a;
    res = PFTD_ACT_NONE;
    for (int i = `PFTD_NEV - 1; i >= 0; i--) begin
      a = act[2*ord[i] +: 2];
      if (ev[ord[i]] && (a != PFTD_ACT_NONE))
        res = a;
    end
    return res;
  endfunction

  function automatic logic apply(input logic cur, input logic [1:0] a, input logic [1:0] frc);
    logic r;
    unique case (a)
      PFTD_ACT_LOW: r = 1'b0;
      PFTD_ACT_HIGH: r = 1'b1;
      PFTD_ACT_TOGGLE: r = ~cur;
      PFTD_ACT_NONE: r = cur;
    endcase
    // force codes 00 and 11 leave the event result alone
    if (frc == 2'h1)
      r = 1'b0;
    else if (frc == 2'h2)
      r = 1'b1;
    return r;
  endfunction

  pftd_cnt_mode_t mode;
  assign mode = pftd_cnt_mode_t'(cnt_mode);
  wire stopped = (mode == PFTD_CNT_STOP);
  wire ev_order_t ord_sel = (mode == PFTD_CNT_UP) ? ORD_UP :
                            (mode == PFTD_CNT_DOWN) ? ORD_DN :
                            cnt_dir_up ? ORD_UDI : ORD_UDD;
  wire [1:0] res_a = stopped ? 2'h0 : resolve(ord_sel, evt, act_a);
  wire [1:0] res_b = stopped ? 2'h0 : resolve(ord_sel, evt, act_b);

  logic aq_a_ff;
  logic aq_b_ff;
  // force is applied after event resolution, so it wins in every mode
  wire nxt_aq_a = apply(aq_a_ff, res_a, force_active_ff[`PFTD_FORCE_A_LSB +: 2]);
  wire nxt_aq_b = apply(aq_b_ff, res_b, force_active_ff[`PFTD_FORCE_B_LSB +: 2]);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      aq_a_ff <= 1'b0;
      aq_b_ff <= 1'b0;
    end else begin
      aq_a_ff <= nxt_aq_a;
      aq_b_ff <= nxt_aq_b;
    end
  end

  // event trigger: two conversion-start channels
  wire pair_sel = event_prescale_register_ff[`PFTD_PS_PAIR_SEL];
  logic [1:0] soc_pulse_ff;

  for (genvar c = 0; c < 2; c++) begin : g_soc
    localparam int SRC_LSB = (c == 0) ? `PFTD_ES_SRC_A_LSB : `PFTD_ES_SRC_B_LSB;
    localparam int EN_BIT = (c == 0) ? `PFTD_ES_EN_A : `PFTD_ES_EN_B;
    localparam int CMP_BIT = (c == 0) ? `PFTD_ES_CMPSEL_A : `PFTD_ES_CMPSEL_B;
    localparam int PS_LSB = (c == 0) ? `PFTD_PS_A_LSB : `PFTD_PS_B_LSB;
    wire [2:0] src = event_select_register_ff[SRC_LSB +: 3];
    wire en = event_select_register_ff[EN_BIT];
    wire cd = event_select_register_ff[CMP_BIT];
    wire c1_up = cd ? cmp_up[2] : cmp_up[0];
    wire c1_dn = cd ? cmp_dn[2] : cmp_dn[0];
    wire c2_up = cd ? cmp_up[3] : cmp_up[1];
    wire c2_dn = cd ? cmp_dn[3] : cmp_dn[1];
    // code 000 is left undefined for software, treated here as no source
    wire src_ev = (src == 3'h1) ? ctr_zero :
                  (src == 3'h2) ? ctr_period :
                  (src == 3'h3) ? (ctr_zero || ctr_period) :
                  (src == 3'h4) ? c1_up :
                  (src == 3'h5) ? c1_dn :
                  (src == 3'h6) ? c2_up :
                  (src == 3'h7) ? c2_dn : 1'b0;
    wire [3:0] prd = pair_sel ? second_prescale_register_ff[PS_LSB +: 4] :
                                event_prescale_register_ff[PS_LSB +: 4];
    wire [3:0] cnt = evt_cnt_ff[c];
    wire [3:0] cnt_inc = cnt + 4'h1;
    // counter holds at the period while disabled so no event is lost
    wire at_prd = (cnt == prd) && (prd != 4'h0);
    wire fire = at_prd && en;

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        evt_cnt_ff[c] <= `PFTD_RST_4;
        soc_pulse_ff[c] <= 1'b0;
      end else begin
        soc_pulse_ff[c] <= fire;
        if (wr_init)
          evt_cnt_ff[c] <= reg_wdata[4*c +: 4];
        else if (fire)
          evt_cnt_ff[c] <= 4'h0;
        else if (src_ev && (cnt != prd))
          evt_cnt_ff[c] <= cnt_inc;
      end
    end
  end

  // dead-band
  wire [13:0] dbc = deadband_control_register_ff;
  wire [1:0] out_mode = dbc[`PFTD_DB_OUT_LSB +: 2];
  wire [1:0] polarity_select = dbc[`PFTD_DB_POL_LSB +: 2];
  wire [1:0] in_mode = dbc[`PFTD_DB_IN_LSB +: 2];
  wire [1:0] output_swap_select = dbc[`PFTD_DB_SWAP_LSB +: 2];
  wire dual_edge_delay_mode = dbc[`PFTD_DB_DUAL];
  wire half_period_delay_clock = dbc[`PFTD_DB_HALF];
  // a half-period tick is emulated by stepping two units per ref_clk cycle
  wire [`PFTD_DLY_W-1:0] dly_step = half_period_delay_clock ? `PFTD_DLY_W'(2) :
                                                               `PFTD_DLY_W'(1);
  logic [1:0] dly_out_ff;
  logic [`PFTD_DLY_W-1:0] dly_cnt_ff [2];
  wire src_rise = in_mode[0] ? aq_b_ff : aq_a_ff;
  wire src_fall = in_mode[1] ? aq_b_ff : aq_a_ff;
  // dual-edge chains the falling stage behind the rising stage
  wire fall_in = dual_edge_delay_mode ? dly_out_ff[0] : src_fall;
  wire [1:0] dly_in = {~fall_in, src_rise};

  for (genvar d = 0; d < 2; d++) begin : g_dly
    localparam int LD_LSB = (d == 0) ? `PFTD_DB_RLD_R_LSB : `PFTD_DB_RLD_F_LSB;
    wire [1:0] ld_mode = dbc[LD_LSB +: 2];
    wire ld = ((ld_mode == 2'h0) && ctr_zero) ||
              ((ld_mode == 2'h1) && ctr_period) ||
              ((ld_mode == 2'h2) && (ctr_zero || ctr_period));
    wire wr_me = (d == 0) ? wr_rise : wr_fall;
    wire [`PFTD_DLY_W:0] cnt_sum = {1'b0, dly_cnt_ff[d]} + {1'b0, dly_step};
    wire done = dly_cnt_ff[d] >= dly_active_ff[d];

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        dly_shadow_ff[d] <= `PFTD_RST_DLY;
        dly_active_ff[d] <= `PFTD_RST_DLY;
        dly_cnt_ff[d] <= `PFTD_RST_DLY;
        dly_out_ff[d] <= 1'b0;
      end else begin
        if (wr_me)
          dly_shadow_ff[d] <= reg_wdata[`PFTD_DLY_W-1:0];
        if (ld)
          dly_active_ff[d] <= dly_shadow_ff[d];
        // output goes high only after input stays high for the delay
        if (!dly_in[d]) begin
          dly_cnt_ff[d] <= `PFTD_RST_DLY;
          dly_out_ff[d] <= 1'b0;
        end else if (done) begin
          dly_out_ff[d] <= 1'b1;
        end else begin
          dly_cnt_ff[d] <= cnt_sum[`PFTD_DLY_W] ? {`PFTD_DLY_W{1'b1}} :
                                                  cnt_sum[`PFTD_DLY_W-1:0];
        end
      end
    end
  end

  wire red_out = dly_out_ff[0];
  wire fed_out = ~dly_out_ff[1];
  // dual-edge leaves a path meaningful only if bypassed or swapped away
  wire path_a_raw = out_mode[0] ? red_out : aq_a_ff;
  wire path_b_raw = out_mode[1] ? fed_out : aq_b_ff;
  wire path_a = path_a_raw ^ polarity_select[0];
  wire path_b = path_b_raw ^ polarity_select[1];
  wire nxt_out_a = output_swap_select[1] ? path_b : path_a;
  wire nxt_out_b = (output_swap_select == 2'h1 || output_swap_select == 2'h3) ?
                   path_a : path_b;

  logic pwm_a_ff;
  logic pwm_b_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pwm_a_ff <= 1'b0;
      pwm_b_ff <= 1'b0;
    end else begin
      pwm_a_ff <= nxt_out_a;
      pwm_b_ff <= nxt_out_b;
    end
  end

  // read port
  wire [15:0] status = {8'h00, evt_cnt_ff[1], evt_cnt_ff[0]};
  // only three bits of the b count fit beside the pair select; full counts live at word 9
  wire [15:0] ps1_rd = {event_prescale_register_ff[15], evt_cnt_ff[1][2:0],
                        event_prescale_register_ff[11:8], evt_cnt_ff[0],
                        event_prescale_register_ff[3:0]};
  wire [15:0] nxt_rdata =
    !reg_rd ? 16'h0000 :
    (reg_addr == `PFTD_ADDR_FORCE) ? {12'h000, force_shadow_ff} :
    (reg_addr == `PFTD_ADDR_FORCE_RELOAD) ? {14'h0000, force_reload_select_ff} :
    (reg_addr == `PFTD_ADDR_EVT_SEL) ? event_select_register_ff :
    (reg_addr == `PFTD_ADDR_EVT_PRESCALE) ? ps1_rd :
    (reg_addr == `PFTD_ADDR_SECOND_PRESCALE) ? {evt_cnt_ff[1],
      second_prescale_register_ff[11:8], evt_cnt_ff[0], second_prescale_register_ff[3:0]} :
    (reg_addr == `PFTD_ADDR_CNT_INIT) ? {8'h00, counter_init_register_ff} :
    (reg_addr == `PFTD_ADDR_DB_CTRL) ? {2'h0, dbc} :
    (reg_addr == `PFTD_ADDR_RISE_DLY) ? {2'h0, dly_shadow_ff[0]} :
    (reg_addr == `PFTD_ADDR_FALL_DLY) ? {2'h0, dly_shadow_ff[1]} :
    (reg_addr == `PFTD_ADDR_STATUS) ? (status | {13'h0000, pwm_b_ff, pwm_a_ff, 1'b0} << 8) :
    16'h0000;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      rdata_ff <= `PFTD_RST_16;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;
  assign pwm_output_a = pwm_a_ff;
  assign pwm_output_b = pwm_b_ff;
  assign conversion_start_pulse_a = soc_pulse_ff[0];
  assign conversion_start_pulse_b = soc_pulse_ff[1];

endmodule
`default_nettype wire

// ### pftd_params.svh
// offsets, field positions and reset values of the pwm force/trigger/dead-band block
// assumes a 4-bit word-indexed register port with 16-bit data
`ifndef PFTD_PARAMS_SVH
`define PFTD_PARAMS_SVH

`define PFTD_AW 4
`define PFTD_DW 16

`define PFTD_ADDR_FORCE 4'h0
`define PFTD_ADDR_FORCE_RELOAD 4'h1
`define PFTD_ADDR_EVT_SEL 4'h2
`define PFTD_ADDR_EVT_PRESCALE 4'h3
`define PFTD_ADDR_SECOND_PRESCALE 4'h4
`define PFTD_ADDR_CNT_INIT 4'h5
`define PFTD_ADDR_DB_CTRL 4'h6
`define PFTD_ADDR_RISE_DLY 4'h7
`define PFTD_ADDR_FALL_DLY 4'h8
`define PFTD_ADDR_STATUS 4'h9

`define PFTD_RST_16 16'h0000
`define PFTD_RST_2 2'h0
`define PFTD_RST_4 4'h0
`define PFTD_RST_DLY 14'h0000

// force register fields
`define PFTD_FORCE_A_LSB 0
`define PFTD_FORCE_B_LSB 2
// event select register fields
`define PFTD_ES_INTERRUPT_SOURCE_SELECT_LSB 0
`define PFTD_ES_INTERRUPT_ENABLE_BIT 3
`define PFTD_ES_CMPSEL_A 4
`define PFTD_ES_CMPSEL_B 5
`define PFTD_ES_SRC_A_LSB 8
`define PFTD_ES_EN_A 11
`define PFTD_ES_SRC_B_LSB 12
`define PFTD_ES_EN_B 15
// prescale fields: period of ch A in [3:0], ch B in [11:8]
`define PFTD_PS_A_LSB 0
`define PFTD_PS_B_LSB 8
`define PFTD_PS_PAIR_SEL 15
// dead-band control fields
`define PFTD_DB_OUT_LSB 0
`define PFTD_DB_POL_LSB 2
`define PFTD_DB_IN_LSB 4
`define PFTD_DB_RLD_R_LSB 6
`define PFTD_DB_RLD_F_LSB 8
`define PFTD_DB_SWAP_LSB 10
`define PFTD_DB_DUAL 12
`define PFTD_DB_HALF 13
`define PFTD_DB_USED 14'h3fff
`define PFTD_DLY_W 14

// action-qualifier event indices
`define PFTD_EV_ZRO 4'd0
`define PFTD_EV_PRD 4'd1
`define PFTD_EV_T1U 4'd2
`define PFTD_EV_T1D 4'd3
`define PFTD_EV_T2U 4'd4
`define PFTD_EV_T2D 4'd5
`define PFTD_EV_CBU 4'd6
`define PFTD_EV_CBD 4'd7
`define PFTD_EV_CAU 4'd8
`define PFTD_EV_CAD 4'd9
`define PFTD_NEV 10

`endif

// ### pftd_pkg.sv
// types shared by the pwm force/trigger/dead-band block
// assumes nothing beyond a SystemVerilog compiler
package pftd_pkg;
  typedef enum logic [1:0] {
    PFTD_CNT_UP,
    PFTD_CNT_DOWN,
    PFTD_CNT_UPDOWN,
    PFTD_CNT_STOP
  } pftd_cnt_mode_t;

  typedef enum logic [1:0] {
    PFTD_ACT_NONE,
    PFTD_ACT_LOW,
    PFTD_ACT_HIGH,
    PFTD_ACT_TOGGLE
  } pftd_act_t;

  typedef enum logic [1:0] {
    PFTD_LD_ZERO,
    PFTD_LD_PERIOD,
    PFTD_LD_EITHER,
    PFTD_LD_NONE
  } pftd_load_t;
endpackage

// ### pftd_asserts.sv
// port checker of the pwm force/trigger/dead-band block
// assumes it is bound onto pftd_core, one clock domain
`include "pftd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pftd_asserts (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`PFTD_AW-1:0] reg_addr,
  input wire logic [`PFTD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`PFTD_DW-1:0] reg_rdata,
  input wire logic conversion_start_pulse_a,
  input wire logic conversion_start_pulse_b
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // write, one idle cycle with no other write, then read of the same word
  sequence wr_gap_rd(a);
    reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a;
  endsequence
  property readback(a, m);
    wr_gap_rd(a) |=> (reg_rdata & m) == ($past(reg_wdata, 3) & m);
  endproperty
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > `PFTD_ADDR_STATUS |=> reg_rdata == 16'h0000)
    else $error("unmapped word did not read zero");
  chk_pulse_a_width: assert property (conversion_start_pulse_a |=> !conversion_start_pulse_a)
    else $error("trigger pulse a longer than one cycle");
  chk_pulse_b_width: assert property (conversion_start_pulse_b |=> !conversion_start_pulse_b)
    else $error("trigger pulse b longer than one cycle");
  chk_force_fields: assert property (readback(`PFTD_ADDR_FORCE, 16'h000f))
    else $error("force fields read back wrong");
  chk_evsel_fields: assert property (readback(`PFTD_ADDR_EVT_SEL, 16'hff3f))
    else $error("event select fields read back wrong");
  chk_reload_field: assert property (readback(`PFTD_ADDR_FORCE_RELOAD, 16'h0003))
    else $error("force reload select read back wrong");
  chk_second_periods: assert property (readback(`PFTD_ADDR_SECOND_PRESCALE, 16'h0f0f))
    else $error("second period fields read back wrong");
endmodule
bind pftd_core pftd_asserts chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conversion_start_pulse_a(conversion_start_pulse_a),
  .conversion_start_pulse_b(conversion_start_pulse_b)
);
`default_nettype wire

// ### pftd_stage_model.sv
// converter trigger inputs fed by the pwm pair: pulse counts and width watch
// assumes registered trigger pulses on ref_clk, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module pftd_stage_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic trig_a,
  input wire logic trig_b,
  output var logic [7:0] trig_a_cnt,
  output var logic [7:0] trig_b_cnt,
  output var logic wide_err
);
  logic trig_a_ff;
  logic trig_b_ff;
  // a converter starts on an edge, so a held level counts once only
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trig_a_ff <= 1'b0;
      trig_b_ff <= 1'b0;
      trig_a_cnt <= 8'h00;
      trig_b_cnt <= 8'h00;
      wide_err <= 1'b0;
    end else begin
      trig_a_ff <= trig_a;
      trig_b_ff <= trig_b;
      if (trig_a && !trig_a_ff)
        trig_a_cnt <= trig_a_cnt + 8'h01;
      if (trig_b && !trig_b_ff)
        trig_b_cnt <= trig_b_cnt + 8'h01;
      if ((trig_a && trig_a_ff) || (trig_b && trig_b_ff))
        wide_err <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### test_pftd_core.sv
// self-checking bench of the pwm force/trigger/dead-band block
// assumes pftd_core, the stage model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_pftd_core;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [1:0] cnt_mode = 2'h1;
  logic ctr_zero = 1'b0;
  logic ctr_period = 1'b0;
  logic t1_dn = 1'b0;
  logic [3:0] cmp_up = 4'h0;
  logic [3:0] cmp_dn = 4'h0;
  // zero high, period low, t1 down low, cmp b down high
  logic [19:0] act_a = 20'h08046;
  logic [3:0] exa = 4'h3;
  logic [3:0] exb = 4'ha;
  logic pwm_a, pwm_b, soc_a, soc_b, wide_err;
  logic [7:0] na, nb, n0;
  logic [15:0] rv;
  // edges until a delayed edge shows: 3 whole cycles, 3 half cycles, 3 then 0 chained
  int dly_wait [3] = '{5, 4, 6};
  int bad_count = 0;
  int comparisons = 0;
  always #50 ref_clk = ~ref_clk;
  pftd_core DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_mode(cnt_mode),
    .cnt_dir_up(1'b1), .ctr_zero(ctr_zero), .ctr_period(ctr_period), .t1_up(1'b0),
    .t1_dn(t1_dn), .t2_up(1'b0), .t2_dn(1'b0), .cmp_up(cmp_up), .cmp_dn(cmp_dn),
    .act_a(act_a), .act_b(20'h00000), .pwm_output_a(pwm_a), .pwm_output_b(pwm_b),
    .conversion_start_pulse_a(soc_a), .conversion_start_pulse_b(soc_b)
  );
  pftd_stage_model far (
    .ref_clk(ref_clk), .reset_n(reset_n), .trig_a(soc_a), .trig_b(soc_b),
    .trig_a_cnt(na), .trig_b_cnt(nb), .wide_err(wide_err)
  );
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmpw(input logic [15:0] g, input logic [15:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cmpb(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata;
  endtask
  // e: {cmp c up, cmp a up, cmp b down, t1 down, period, zero}
  task automatic ev(input logic [5:0] e);
    @(posedge ref_clk);
    {cmp_up[2], cmp_up[0], cmp_dn[1], t1_dn, ctr_period, ctr_zero} <= e;
    @(posedge ref_clk);
    {cmp_up[2], cmp_up[0], cmp_dn[1], t1_dn, ctr_period, ctr_zero} <= 6'h00;
  endtask
  task automatic see(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic pulses(input logic [5:0] e, input int n, input logic [7:0] x);
    n0 = na;
    repeat (n) ev(e);
    see(4);
    cmpw({8'h00, na - n0}, {8'h00, x}, "trigger pulses");
  endtask
  initial begin
    #(100 * 4000);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(4'h2);
    cmpw(rv, 16'h0000, "event select reset");
    wr(4'h2, 16'h0c00);
    rd(4'h2);
    cmpw(rv & 16'hff3f, 16'h0c00, "event select");
    wr(4'hf, 16'hffff);
    rd(4'hf);
    cmpw(rv, 16'h0000, "unmapped");
    $display("test registers done");
    ev(6'h03);
    see(2);
    cmpb(pwm_a, 1'b1, "down zero over period");
    ev(6'h0c);
    see(2);
    cmpb(pwm_a, 1'b0, "down t1 over cmp b");
    @(posedge ref_clk);
    cnt_mode <= 2'h0;
    ev(6'h01);
    see(2);
    cmpb(pwm_a, 1'b1, "up zero alone");
    ev(6'h03);
    see(2);
    cmpb(pwm_a, 1'b0, "up period over zero");
    $display("test priority done");
    wr(4'h0, 16'h000b);
    rd(4'h0);
    cmpw(rv & 16'h000f, 16'h000b, "force fields");
    see(3);
    cmpb(pwm_b, 1'b0, "no load without reload");
    ev(6'h01);
    see(1);
    cmpb(pwm_b, 1'b0, "force not yet seen");
    cmpb(pwm_a, 1'b1, "code 11 no force");
    see(1);
    cmpb(pwm_b, 1'b1, "force high seen");
    wr(4'h1, 16'h0001);
    rd(4'h1);
    cmpw(rv & 16'h0003, 16'h0001, "reload select");
    wr(4'h0, 16'h0006);
    ev(6'h01);
    see(3);
    cmpb(pwm_b, 1'b1, "zero not reloading");
    ev(6'h02);
    see(3);
    cmpb(pwm_a, 1'b1, "force high a");
    cmpb(pwm_b, 1'b0, "force low b");
    ev(6'h02);
    see(2);
    cmpb(pwm_a, 1'b1, "force over period action");
    $display("test force done");
    for (int s = 0; s < 4; s++) begin
      wr(4'h6, 16'(s << 10));
      see(3);
      cmpb(pwm_a, exa[s], "swap a");
      cmpb(pwm_b, exb[s], "swap b");
    end
    wr(4'h6, 16'h0000);
    $display("test swap done");
    wr(4'h3, 16'h0002);
    pulses(6'h10, 6, 8'h03);
    rd(4'h9);
    cmpw(rv & 16'h000f, 16'h0000, "count restarted");
    wr(4'h2, 16'h0c10);
    pulses(6'h10, 2, 8'h00);
    pulses(6'h20, 1, 8'h00);
    rd(4'h9);
    cmpw(rv & 16'h000f, 16'h0001, "cmp c counted");
    wr(4'h5, 16'h0000);
    wr(4'h4, 16'h0003);
    rd(4'h4);
    cmpw(rv & 16'h0f0f, 16'h0003, "second periods");
    wr(4'h3, 16'h8002);
    pulses(6'h20, 5, 8'h01);
    wr(4'h2, 16'h0410);
    pulses(6'h20, 4, 8'h00);
    wr(4'h3, 16'h0002);
    wr(4'h5, 16'h0001);
    rd(4'h9);
    cmpw(rv & 16'h000f, 16'h0001, "count from init");
    wr(4'h2, 16'h0c10);
    pulses(6'h20, 1, 8'h01);
    cmpb(wide_err, 1'b0, "pulse width");
    cmpw({8'h00, nb}, 16'h0000, "channel b disabled");
    $display("test trigger done");
    wr(4'h7, 16'h0003);
    ev(6'h01);
    for (int h = 0; h < 3; h++) begin
      wr(4'h6, (h == 0) ? 16'h0001 : (h == 1) ? 16'h2001 : 16'h1002);
      wr(4'h0, 16'h0005);
      ev(6'h02);
      see(3);
      wr(4'h0, 16'h0006);
      ev(6'h02);
      see(dly_wait[h]);
      cmpb((h == 2) ? pwm_b : pwm_a, 1'b0, "delayed edge too early");
      see(1);
      cmpb((h == 2) ? pwm_b : pwm_a, 1'b1, "delayed edge missing");
    end
    $display("test dead-band done");
    stop_test();
  end
endmodule
`default_nettype wire
